// File: include/srs_pkg.sv
/*
 * Shared constants and carrier types for the serial register access slave.
 * Assumes a 250 MHz core clock and a host-driven serial clock sampled as data.
 */
package srs_pkg;
    // =========================================================
    // Register map groups
    localparam logic [6:0] WIDE_LAST   = 7'h1f;
    localparam logic [6:0] ID_REG      = 7'h1f;
    localparam logic [6:0] CFG_FIRST   = 7'h20;
    localparam logic [6:0] CFG_LAST    = 7'h2a;
    localparam logic [6:0] STATUS_REG  = 7'h30;
    localparam logic [6:0] FIFO_REG    = 7'h32;
    localparam logic [6:0] CFG_EXTRA   = 7'h34;
    localparam logic [15:0] RESET_WORD = 16'h0000;
    // Arbitrary neutral identity value
    localparam logic [15:0] SILICON_ID = 16'h0a5a;

    // =========================================================
    // Bit counting and settle times
    localparam logic [2:0] BIT_LAST      = 3'h7;
    localparam int         CLOCK_MHZ     = 250;
    localparam int         SETTLE_US     = 150;
    localparam int         SETTLE_AC_US  = 350;
    localparam int         SETTLE_CYC    = SETTLE_US * CLOCK_MHZ;
    localparam int         SETTLE_AC_CYC = SETTLE_AC_US * CLOCK_MHZ;

    typedef enum logic [1:0] {
        SRS_IDLE,
        SRS_CMD,
        SRS_DATA
    } srs_state_t;

    // Register access request toward the register store
    typedef struct packed {
        logic       write;
        logic [6:0] addr;
        logic [7:0] data;
        logic       high;
    } srs_req_t;
endpackage

// File: rtl/srs_fifo.sv
/*
 * Parameterised FIFO with valid/ready on both sides.
 * Assumes a single clock domain and asynchronous active-high reset.
 */
`timescale 1ns/1ns
`default_nettype none
module srs_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input  wire logic             clock,
    input  wire logic             rst,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wp_q, wp_d, rp_q, rp_d;
    logic             push, pop;

    assign in_ready  = (wp_q - rp_q) != (AW+1)'(DEPTH);
    assign out_valid = wp_q != rp_q;
    assign out_data  = mem[rp_q[AW-1:0]];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        wp_d = push ? wp_q + 1'b1 : wp_q;
        rp_d = pop ? rp_q + 1'b1 : rp_q;
    end

    always_ff @(posedge clock) begin
        if (push) begin
            mem[wp_q[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            wp_q <= '0;
            rp_q <= '0;
        end else begin
            wp_q <= wp_d;
            rp_q <= rp_d;
        end
    end
endmodule
`default_nettype wire

// File: rtl/srs_slave.sv
/*
 * Four-wire serial slave giving a host access to the radio's register store.
 * Assumes the host clock idles low, data sampled on rising and shifted on falling edges.
 */
`timescale 1ns/1ns
`default_nettype none
module srs_slave #(
    parameter int FIFO_DEPTH = 16
) (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        rst,
    // Serial pins
    input  wire logic        ss_n,
    input  wire logic        sclk,
    input  wire logic        mosi,
    output logic             miso,
    output logic             miso_oe,
    // Radio side: status and FIFO
    input  wire logic [15:0] status_register,
    input  wire logic        tx_fifo_ready,
    output logic             tx_fifo_valid,
    output logic [7:0]       tx_fifo_data,
    input  wire logic        rx_fifo_valid,
    output logic             rx_fifo_ready,
    input  wire logic [7:0]  rx_fifo_data,
    // Register store port
    output logic [6:0]       reg_addr,
    output logic [15:0]      reg_wdata,
    output logic             reg_we,
    input  wire logic [15:0] reg_rdata
);
    // =========================================================
    // Pin synchronisers: three stages, change taken when last two agree
    logic [2:0] ss_s_q, ck_s_q, mo_s_q;
    logic       ss_q, ck_q, mo_q, ck_prev_q;
    logic       ss_d, ck_d, mo_d;

    always_comb begin
        ss_d = (ss_s_q[1] == ss_s_q[2]) ? ss_s_q[2] : ss_q;
        ck_d = (ck_s_q[1] == ck_s_q[2]) ? ck_s_q[2] : ck_q;
        mo_d = (mo_s_q[1] == mo_s_q[2]) ? mo_s_q[2] : mo_q;
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ss_s_q    <= 3'h7;
            ck_s_q    <= 3'h0;
            mo_s_q    <= 3'h0;
            ss_q      <= 1'b1;
            ck_q      <= 1'b0;
            mo_q      <= 1'b0;
            ck_prev_q <= 1'b0;
        end else begin
            ss_s_q    <= {ss_s_q[1:0], ss_n};
            ck_s_q    <= {ck_s_q[1:0], sclk};
            mo_s_q    <= {mo_s_q[1:0], mosi};
            ss_q      <= ss_d;
            ck_q      <= ck_d;
            mo_q      <= mo_d;
            ck_prev_q <= ck_q;
        end
    end

    logic rise, fall, sel;
    assign sel  = !ss_q;
    assign rise = sel && ck_q && !ck_prev_q;
    assign fall = sel && !ck_q && ck_prev_q;

    // =========================================================
    // Transaction state
    srs_pkg::srs_state_t st_q, st_d;
    logic [2:0]  bit_q, bit_d;
    logic [7:0]  sh_q, sh_d, tx_q, tx_d;
    logic [6:0]  addr_q, addr_d;
    logic        rd_q, rd_d, hi_q, hi_d;
    logic [7:0]  lo_keep_q, lo_keep_d;
    logic [15:0] wd_q, wd_d;
    logic        we_q, we_d, push_q, push_d, pop_q, pop_d;
    logic [7:0]  pd_q, pd_d;
    logic        f_in_ready, f_out_valid;
    logic [7:0]  f_out_data, byte_in;
    logic [6:0]  ra_q, ra_d;
    logic [15:0] rdw;

    function automatic logic is_wide(input logic [6:0] a);
        is_wide = a <= srs_pkg::WIDE_LAST;
    endfunction

    function automatic logic [15:0] rd_word(input logic [6:0] a, input logic [15:0] r);
        rd_word = (a == srs_pkg::ID_REG) ? srs_pkg::SILICON_ID : r;
    endfunction

    assign byte_in  = {sh_q[6:0], mo_q};
    assign rdw      = rd_word(addr_q, reg_rdata);
    // Write address kept apart so the step to the next register cannot race the strobe
    assign reg_addr = ra_q;

    always_comb begin
        st_d = st_q; bit_d = bit_q; sh_d = sh_q; tx_d = tx_q;
        addr_d = addr_q; rd_d = rd_q; hi_d = hi_q; lo_keep_d = lo_keep_q;
        wd_d = wd_q; we_d = 1'b0; push_d = push_q && !f_in_ready;
        pd_d = pd_q; pop_d = 1'b0;
        if (!sel) begin
            st_d  = srs_pkg::SRS_IDLE;
            bit_d = '0;
        end else begin
            if (st_q == srs_pkg::SRS_IDLE) begin
                st_d  = srs_pkg::SRS_CMD;
                tx_d  = status_register[15:8];
                bit_d = '0;
            end
            if (rise) begin
                sh_d  = byte_in;
                bit_d = bit_q + 3'h1;
                if (bit_q == srs_pkg::BIT_LAST) begin
                    unique case (st_q)
                        srs_pkg::SRS_CMD: begin
                            rd_d   = byte_in[7];
                            addr_d = byte_in[6:0];
                            hi_d   = 1'b1;
                            st_d   = srs_pkg::SRS_DATA;
                        end
                        srs_pkg::SRS_DATA: begin
                            if (!rd_q) begin
                                if (addr_q == srs_pkg::FIFO_REG) begin
                                    push_d = 1'b1;
                                    pd_d   = byte_in;
                                end else if (is_wide(addr_q) && hi_q) begin
                                    lo_keep_d = byte_in;
                                    hi_d      = 1'b0;
                                end else if (is_wide(addr_q)) begin
                                    wd_d   = {lo_keep_q, byte_in};
                                    we_d   = addr_q != srs_pkg::ID_REG;
                                    hi_d   = 1'b1;
                                    addr_d = addr_q + 7'h1;
                                end else begin
                                    wd_d   = {8'h00, byte_in};
                                    we_d   = 1'b1;
                                    addr_d = addr_q + 7'h1;
                                end
                            end
                            if (rd_q && addr_q == srs_pkg::FIFO_REG) begin
                                pop_d = 1'b1;
                            end else if (rd_q && (!is_wide(addr_q) || !hi_q)) begin
                                addr_d = addr_q + 7'h1;
                                hi_d   = 1'b1;
                            end else if (rd_q) begin
                                hi_d = 1'b0;
                            end
                        end
                        default: ;
                    endcase
                end
            end
            if (fall) begin
                if (bit_q == 3'h0 && st_q == srs_pkg::SRS_DATA && rd_q) begin
                    if (addr_q == srs_pkg::FIFO_REG) begin
                        tx_d = f_out_valid ? f_out_data : 8'h00;
                    end else if (is_wide(addr_q)) begin
                        tx_d = hi_q ? rdw[15:8] : rdw[7:0];
                    end else begin
                        tx_d = reg_rdata[7:0];
                    end
                end else if (bit_q == 3'h0 && st_q == srs_pkg::SRS_DATA) begin
                    tx_d = sh_q; // Echo of the written byte
                end else begin
                    tx_d = {tx_q[6:0], 1'b0};
                end
            end
        end
        ra_d = we_d ? addr_q : addr_d;
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            st_q      <= srs_pkg::SRS_IDLE;
            bit_q     <= '0;
            sh_q      <= '0;
            tx_q      <= '0;
            addr_q    <= '0;
            rd_q      <= 1'b0;
            hi_q      <= 1'b1;
            lo_keep_q <= '0;
            wd_q      <= srs_pkg::RESET_WORD;
            we_q      <= 1'b0;
            push_q    <= 1'b0;
            pd_q      <= '0;
            pop_q     <= 1'b0;
            ra_q      <= '0;
        end else begin
            st_q      <= st_d;
            bit_q     <= bit_d;
            sh_q      <= sh_d;
            tx_q      <= tx_d;
            addr_q    <= addr_d;
            rd_q      <= rd_d;
            hi_q      <= hi_d;
            lo_keep_q <= lo_keep_d;
            wd_q      <= wd_d;
            we_q      <= we_d;
            push_q    <= push_d;
            pd_q      <= pd_d;
            pop_q     <= pop_d;
            ra_q      <= ra_d;
        end
    end

    // MISO only driven while selected, so a shared bus stays free
    assign miso      = tx_q[7];
    assign miso_oe   = sel;
    assign reg_wdata = wd_q;
    assign reg_we    = we_q;

    // =========================================================
    // Write path toward the packet FIFO; a full FIFO holds one pending byte until ready, and the next written byte replaces it
    srs_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_txf (
        .clock     (clock),
        .rst       (rst),
        .in_valid  (push_q),
        .in_ready  (f_in_ready),
        .in_data   (pd_q),
        .out_valid (tx_fifo_valid),
        .out_ready (tx_fifo_ready),
        .out_data  (tx_fifo_data)
    );
    assign f_out_valid   = rx_fifo_valid;
    assign f_out_data    = rx_fifo_data;
    assign rx_fifo_ready = pop_q;

    // =========================================================
    // Checks
    chk_idle_no_drive: assert property (@(posedge clock) disable iff (rst)
        ss_q |-> !miso_oe)
        else $error("miso driven while idle");
    chk_cmd_status: assert property (@(posedge clock) disable iff (rst)
        (st_q == srs_pkg::SRS_IDLE && sel) |=> tx_q == $past(status_register[15:8]))
        else $error("status byte not loaded");
    chk_cmd_capture: assert property (@(posedge clock) disable iff (rst)
        (rise && st_q == srs_pkg::SRS_CMD && bit_q == srs_pkg::BIT_LAST)
        |=> st_q == srs_pkg::SRS_DATA && hi_q && {rd_q, addr_q} == $past(byte_in))
        else $error("command byte not captured");
    chk_shift_msb: assert property (@(posedge clock) disable iff (rst)
        (fall && st_q == srs_pkg::SRS_CMD) |=> tx_q == {$past(tx_q[6:0]), 1'b0})
        else $error("status byte not shifted msb first");
    chk_wide_order: assert property (@(posedge clock) disable iff (rst)
        (fall && bit_q == 3'h0 && st_q == srs_pkg::SRS_DATA && rd_q && is_wide(addr_q))
        |=> tx_q == ($past(hi_q) ? $past(rdw[15:8]) : $past(rdw[7:0])))
        else $error("wide read byte order wrong");
    chk_fifo_no_inc: assert property (@(posedge clock) disable iff (rst)
        (st_q == srs_pkg::SRS_DATA && addr_q == srs_pkg::FIFO_REG && sel)
        |=> addr_q == srs_pkg::FIFO_REG)
        else $error("fifo address moved");
    chk_fifo_empty: assert property (@(posedge clock) disable iff (rst)
        (fall && bit_q == 3'h0 && st_q == srs_pkg::SRS_DATA && rd_q
         && addr_q == srs_pkg::FIFO_REG && !f_out_valid) |=> tx_q == 8'h00)
        else $error("empty fifo read not zero");
    chk_pop_pulse: assert property (@(posedge clock) disable iff (rst)
        rx_fifo_ready |=> !rx_fifo_ready)
        else $error("fifo pop longer than one cycle");
    chk_partial_drop: assert property (@(posedge clock) disable iff (rst)
        !sel |=> bit_q == 3'h0 && st_q != srs_pkg::SRS_DATA)
        else $error("partial byte kept");
    chk_bit_wrap: assert property (@(posedge clock) disable iff (rst)
        (rise && bit_q == srs_pkg::BIT_LAST) |=> bit_q == 3'h0)
        else $error("bit count did not wrap");
    chk_read_no_write: assert property (@(posedge clock) disable iff (rst)
        (rd_q && st_q == srs_pkg::SRS_DATA) |=> !we_q && (!push_q || $past(push_q)))
        else $error("write during read");
    chk_id_ro: assert property (@(posedge clock) disable iff (rst)
        reg_we |-> reg_addr != srs_pkg::ID_REG)
        else $error("identity written");
    chk_wide_pair: assert property (@(posedge clock) disable iff (rst)
        (reg_we && is_wide($past(addr_q))) |-> $past(hi_q) == 1'b0)
        else $error("wide write without high byte");
    chk_hi_hold: assert property (@(posedge clock) disable iff (rst)
        (rise && bit_q == srs_pkg::BIT_LAST && st_q == srs_pkg::SRS_DATA
         && is_wide(addr_q) && hi_q) |=> addr_q == $past(addr_q) && !hi_q)
        else $error("address moved inside a wide register");
    chk_addr_step: assert property (@(posedge clock) disable iff (rst)
        reg_we |-> addr_q == $past(addr_q) + 7'h1)
        else $error("address not stepped");
    chk_cfg_low: assert property (@(posedge clock) disable iff (rst)
        (reg_we && !is_wide(reg_addr)) |-> reg_wdata[15:8] == 8'h00)
        else $error("narrow register upper byte not clear");
    chk_we_pulse: assert property (@(posedge clock) disable iff (rst)
        reg_we |=> !reg_we)
        else $error("write strobe longer than one cycle");
endmodule
`default_nettype wire

// File: tb/srs_host_model.sv
/*
 * Behavioural host driving three serial pins of the slave and sampling the fourth, miso.
 * Assumes mode 0: clock idles low, device shifts on falls, host samples on rises.
 */
`timescale 1ns/1ns
`default_nettype none
module srs_host_model (
    // Serial pins
    output logic      ss_n,
    output logic      sclk,
    output logic      mosi,
    input  wire logic miso
);
    logic [7:0] last_rx;
    event       got;

    initial begin
        ss_n = 1'b1;
        sclk = 1'b0;
        mosi = 1'b0;
    end

    task automatic sel();
        ss_n = 1'b0;
        #100;
    endtask

    // Inactive time kept well above the minimum
    task automatic desel();
        #100;
        ss_n = 1'b1;
        #250;
    endtask

    // Synthesizer settle wait after a channel change
    task automatic settle(input logic auto_cal);
        if (auto_cal) #(srs_pkg::SETTLE_AC_US * 1000);
        else #(srs_pkg::SETTLE_US * 1000);
    endtask

    // Clock stands low between bits and between frames
    task automatic xfer(input logic [7:0] tx, input int nbits, input int gap);
        logic [7:0] rx;
        rx = 8'h00;
        for (int i = 0; i < nbits; i++) begin
            mosi = tx[7-i];
            #60;
            sclk = 1'b1;
            rx = {rx[6:0], miso};
            #65;
            sclk = 1'b0;
        end
        // Released line shows the inverse, never a stale value
        mosi = ~mosi;
        #(gap);
        if (nbits == 8) begin
            last_rx = rx;
            ->got;
        end
    endtask
endmodule
`default_nettype wire

// File: tb/test_spi_register_access_slave.sv
/*
 * Self-checking bench for the serial register access slave.
 * Assumes the package and the host model are compiled before it.
 */
`timescale 1ns/1ns
`default_nettype none
module test_spi_register_access_slave;
    logic        clock, rst, ss_n, sclk, mosi, miso, miso_oe, reg_we, drain;
    logic [15:0] status_register, reg_wdata, reg_rdata;
    logic        tx_fifo_ready, tx_fifo_valid, rx_fifo_valid, rx_fifo_ready;
    logic [7:0]  tx_fifo_data, rx_fifo_data;
    logic [6:0]  reg_addr, ra;
    logic [15:0] regs [128];
    logic [15:0] mdl [128];
    logic [22:0] wq [$];
    logic [7:0]  fq [$], rxq [$], fexp [$];
    logic [8:0]  rq [$], e_r;
    int          failures, n_checks;

    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    srs_slave #(.FIFO_DEPTH(16)) DUT (
        .clock(clock), .rst(rst), .ss_n(ss_n), .sclk(sclk), .mosi(mosi),
        .miso(miso), .miso_oe(miso_oe), .status_register(status_register),
        .tx_fifo_ready(tx_fifo_ready), .tx_fifo_valid(tx_fifo_valid),
        .tx_fifo_data(tx_fifo_data), .rx_fifo_valid(rx_fifo_valid),
        .rx_fifo_ready(rx_fifo_ready), .rx_fifo_data(rx_fifo_data),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_rdata(reg_rdata)
    );
    srs_host_model host (.ss_n(ss_n), .sclk(sclk), .mosi(mosi), .miso(miso));

    // ==========================================================
    // Radio side models
    assign reg_rdata = regs[reg_addr];
    always @(negedge clock) begin
        if (reg_we) regs[reg_addr] <= reg_wdata;
        if (rx_fifo_ready && rxq.size() > 0) void'(rxq.pop_front());
        #1;
        rx_fifo_valid = rxq.size() > 0;
        rx_fifo_data  = (rxq.size() > 0) ? rxq[0] : 8'h00;
        tx_fifo_ready = drain & 1'($urandom);
        // Ready is final here, so this is exactly the handshake of the coming edge
        if (!rst && tx_fifo_valid && tx_fifo_ready)
            check({1'b1, tx_fifo_data}, fq.size() > 0 ? {1'b1, fq.pop_front()} : 9'h000);
    end

    // ==========================================================
    // Checking
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Strobe sampled mid-cycle, away from the edge that launches it
    always @(negedge clock) begin
        if (!rst && reg_we)
            check({reg_addr, reg_wdata}, wq.size() > 0 ? wq.pop_front() : '1);
    end

    always @(host.got) begin
        e_r = (rq.size() > 0) ? rq.pop_front() : {1'b1, ~host.last_rx};
        if (e_r[8]) check(host.last_rx, e_r[7:0]);
    end

    task automatic done(input string name);
        $display("test %s finished", name);
    endtask

    task automatic final_report();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // ==========================================================
    // Driver: one framed transaction, notes every expected result
    task automatic frame(input logic rd, input logic [6:0] a, input int n, input int tail);
        logic [6:0] cur;
        logic [7:0] b, hi;
        int         gap;
        cur = a;
        hi  = 8'h00;
        gap = (rd && a == srs_pkg::FIFO_REG) ? 400 : 100;
        @(posedge clock);
        #1 status_register = 16'($urandom);
        rq.push_back({1'b1, status_register[15:8]});
        host.sel();
        check(miso_oe, 1'b1);
        host.xfer({rd, a}, 8, gap);
        for (int i = 0; i < n; i++) begin
            b = 8'($urandom);
            if (!rd) rq.push_back(9'h000);
            if (a == srs_pkg::FIFO_REG) begin
                if (rd) rq.push_back({1'b1, fexp.pop_front()});
                else fq.push_back(b);
            end else if (cur <= srs_pkg::WIDE_LAST) begin
                if (rd) rq.push_back({1'b1, i[0] ? mdl[cur][7:0] : mdl[cur][15:8]});
                else if (i[0] && cur != srs_pkg::ID_REG) begin
                    wq.push_back({cur, hi, b});
                    mdl[cur] = {hi, b};
                end
                hi = b;
                if (i[0]) cur++;
            end else begin
                if (rd) rq.push_back({1'b1, mdl[cur][7:0]});
                else begin
                    wq.push_back({cur, 8'h00, b});
                    mdl[cur][7:0] = b;
                end
                cur++;
            end
            host.xfer(b, 8, gap);
        end
        if (tail > 0) host.xfer(8'($urandom), tail, gap);
        host.desel();
        check(miso_oe, 1'b0);
    endtask

    initial begin
        rst = 1'b1;
        drain = 1'b0;
        status_register = 16'h0000;
        tx_fifo_ready = 1'b0;
        rx_fifo_valid = 1'b0;
        rx_fifo_data = 8'h00;
        failures = 0;
        n_checks = 0;
        void'($urandom(29));
        for (int i = 0; i < 128; i++) begin
            regs[i] = 16'($urandom);
            mdl[i]  = regs[i];
        end
        // Store holds a decoy; the slave must answer the identity itself
        regs[31] = ~srs_pkg::SILICON_ID;
        mdl[31]  = srs_pkg::SILICON_ID;
        repeat (5) @(posedge clock);
        #1 rst = 1'b0;
        repeat (2) @(posedge clock);
        frame(1'b0, 7'h05, 4, 0);
        frame(1'b1, 7'h05, 5, 0);
        done("wide");
        frame(1'b0, srs_pkg::ID_REG, 2, 0);
        frame(1'b1, 7'h1e, 4, 0);
        done("identity");
        frame(1'b0, srs_pkg::CFG_FIRST, 11, 0);
        frame(1'b1, srs_pkg::CFG_FIRST, 11, 0);
        frame(1'b0, srs_pkg::CFG_EXTRA, 1, 0);
        frame(1'b1, srs_pkg::CFG_EXTRA, 1, 0);
        done("config");
        frame(1'b0, 7'h03, 3, 5);
        frame(1'b1, 7'h03, 2, 0);
        done("partial");
        host.settle(1'b0);
        frame(1'b0, srs_pkg::FIFO_REG, 16, 0);
        @(posedge clock);
        check(tx_fifo_valid, 1'b1);
        #1 drain = 1'b1;
        for (int t = 0; t < 2000 && fq.size() > 0; t++) @(posedge clock);
        for (int i = 0; i < 3; i++) begin
            fexp.push_back(8'($urandom));
            rxq.push_back(fexp[i]);
        end
        fexp.push_back(8'h00);
        frame(1'b1, srs_pkg::FIFO_REG, 4, 0);
        done("fifo");
        for (int k = 0; k < 4; k++) begin
            ra = 7'($urandom % 31);
            frame(1'b0, ra, 2, 0);
            frame(1'b1, ra, 2, 0);
        end
        for (int k = 0; k < 4; k++) frame(1'b1, 7'($urandom % 31), 2, 0);
        done("random");
        repeat (20) @(posedge clock);
        check(wq.size() + fq.size() + rq.size(), 0);
        final_report();
    end

    initial begin
        #400_000;
        failures++;
        final_report();
    end
endmodule
`default_nettype wire
